// ### hw/sss_cfg.svh
/*
 * constants of the sensor spi slave: frame layout, register addresses,
 * fault bit positions, reset values and link timing.
 * assumes inclusion by the package and by the design modules.
 */
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH

// frame layout
`define SSS_FRAME_BITS      16
`define SSS_PAR_BIT         15
`define SSS_RW_BIT          14
`define SSS_DATA_BITS       14
`define SSS_BITS_FULL       5'h10
`define SSS_BITS_SAT        5'h1f

// register addresses
`define SSS_ADDR_NOP        14'h0000
`define SSS_ADDR_FAULT      14'h0001
`define SSS_ADDR_PROG       14'h0003
`define SSS_ADDR_NV_FIRST   14'h0016
`define SSS_ADDR_NV_LAST    14'h001a
`define SSS_ADDR_DIAG       14'h3ffc
`define SSS_ADDR_MAG        14'h3ffd
`define SSS_ADDR_ANG_RAW    14'h3ffe
`define SSS_ADDR_ANG_COMP   14'h3fff
`define SSS_NV_COUNT        5

// fault latch bit positions
`define SSS_FLT_PARITY      2
`define SSS_FLT_ADDR        1
`define SSS_FLT_FRAME       0

// reset values
`define SSS_RESET_WORD      14'h0000
`define SSS_RESET_FAULTS    3'h0
`define SSS_RESET_TX        16'h0000

// buffering
`define SSS_FIFO_DEPTH      32

// link timing: fastest serial clock against the system clock
`define SSS_MCLK_PERIOD_NS      25
`define SSS_SCLK_MIN_PERIOD_NS  100
`define SSS_SCLK_MIN_CYC        ((`SSS_SCLK_MIN_PERIOD_NS + `SSS_MCLK_PERIOD_NS - 1) / `SSS_MCLK_PERIOD_NS)

`endif

// ### hw/sss_pkg.sv
/*
 * types of the sensor spi slave: frame phase and the state record.
 * assumes sss_cfg.svh is on the include path.
 */
`include "sss_cfg.svh"

package sss_pkg;

    // which frame the next select-low period carries
    typedef enum logic [0:0] {
        SSS_PH_CMD  = 1'b0,
        SSS_PH_DATA = 1'b1
    } sss_phase_t;

    // all state of the slave
    typedef struct packed {
        sss_phase_t                                        phase;
        logic [4:0]                                        bits;
        logic [`SSS_FRAME_BITS-1:0]                        rx;
        logic [`SSS_FRAME_BITS-1:0]                        tx;
        logic                                              miso;
        logic                                              oe;
        logic [`SSS_DATA_BITS-1:0]                         wr_addr;
        logic [2:0]                                        faults;
        logic [`SSS_DATA_BITS-1:0]                         prog;
        logic [`SSS_NV_COUNT-1:0][`SSS_DATA_BITS-1:0]      nv;
        logic                                              sclk_d;
        logic                                              cs_d;
    } sss_state_t;

endpackage

// ### hw/sss_sync.sv
/*
 * two-flop synchroniser for a group of asynchronous levels.
 * assumes each bit is an independent level from outside the mclk domain.
 */
`timescale 1ns/1ps

module sss_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sss_sync_t;

    sss_sync_t sy_reg;
    sss_sync_t sy_next;

    // first stage feeds only the second
    always_comb begin
        sy_next    = sy_reg;
        sy_next.s1 = async_in;
        sy_next.s2 = sy_reg.s1;
    end

    // reset to the idle level of each pin so no false edge follows reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            sy_reg.s1 <= INIT;
            sy_reg.s2 <= INIT;
        end else begin
            sy_reg <= sy_next;
        end
    end

    assign sync_out = sy_reg.s2;
endmodule

// ### hw/sss_fifo.sv
/*
 * small fifo with a registered read word and valid/ready on both sides.
 * assumes one clock; depth must be a power of two of at least two.
 */
`timescale 1ns/1ps

module sss_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fifo depth must be a power of two of at least two");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic                        ov;
        logic [WIDTH-1:0]            od;
    } sss_fifo_t;

    sss_fifo_t ff_reg;
    sss_fifo_t ff_next;
    logic      push;
    logic      load;

    // push when room, move head into the output word when it is free
    always_comb begin
        ff_next = ff_reg;
        push    = in_valid && (ff_reg.cnt != (AW+1)'(DEPTH));
        load    = (ff_reg.cnt != '0) && (!ff_reg.ov || out_ready);
        if (out_ready && ff_reg.ov) begin
            ff_next.ov = 1'b0;
        end
        if (load) begin
            ff_next.od = ff_reg.mem[ff_reg.rp];
            ff_next.ov = 1'b1;
            ff_next.rp = ff_reg.rp + 1'b1;
        end
        if (push) begin
            ff_next.mem[ff_reg.wp] = in_data;
            ff_next.wp             = ff_reg.wp + 1'b1;
        end
        ff_next.cnt = ff_reg.cnt + (AW+1)'(push) - (AW+1)'(load);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ff_reg <= '0;
        end else begin
            ff_reg <= ff_next;
        end
    end

    assign in_ready  = ff_reg.cnt != (AW+1)'(DEPTH);
    assign out_valid = ff_reg.ov;
    assign out_data  = ff_reg.od;
endmodule

// ### hw/sss_spi_slave.sv
/*
 * serial slave of the angle sensor: command/data frames, pipelined reads,
 * soft-written registers, fault latch and a buffered stream of writes.
 * assumes the link pins are asynchronous to mclk and the sensor values
 * (diagnostics, magnitude, angles) come from logic on mclk.
 */
`timescale 1ns/1ps
`include "sss_cfg.svh"

// How it works
// - link is mode 1: clock idles low, data taken on second edge.
// - each incoming bit is captured on the serial clock falling edge.
// - commands act only at select rising edge, never while shifting.
// - every frame is shifted most significant bit first, both ways.
// - a write is a 16-bit command frame then a 16-bit data frame; a read is one command frame.
// - wrong command parity sets the parity fault bit.
// - returned frame: bit 15 parity, bit 14 error, bits 13:0 data.
// - error bit is high when the preceding frame, command or data, had an error.
// - read value is captured at select rise, shifted out next frame.
// - during the write data frame the old content is returned.
// - the frame after a write data frame returns the new content.
// - the full 14-bit angle is readable as a register.
// - fault latch: parity bit 2, bad address bit 1, framing bit 0.
// - access to a missing register address sets the bad address bit.
// - reading the fault latch clears all its bits.

module sss_spi_slave #(
    parameter int FIFO_DEPTH = `SSS_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                                   mclk,
    input  wire logic                                   rst,
    // serial link
    input  wire logic                                   sclk,
    input  wire logic                                   frame_select_low,
    input  wire logic                                   mosi,
    output logic                                        miso_out,
    output logic                                        miso_oe,
    // sensor values
    input  wire logic [`SSS_DATA_BITS-1:0]              diag_word,
    input  wire logic [`SSS_DATA_BITS-1:0]              magnitude,
    input  wire logic [`SSS_DATA_BITS-1:0]              angle_raw,
    input  wire logic [`SSS_DATA_BITS-1:0]              angle_comp,
    // register contents and status
    output logic [`SSS_DATA_BITS-1:0]                   prog_word,
    output logic [`SSS_NV_COUNT-1:0][`SSS_DATA_BITS-1:0] nv_settings,
    output logic [2:0]                                  fault_latch_register,
    // stream of committed writes
    output logic                                        wr_valid,
    input  wire logic                                   wr_ready,
    output logic [`SSS_DATA_BITS-1:0]                   wr_addr,
    output logic [`SSS_DATA_BITS-1:0]                   wr_data
);
    localparam int WW = 2 * `SSS_DATA_BITS;

    // the sampler needs two mclk cycles per serial clock half period
    if (`SSS_SCLK_MIN_CYC / 2 < 2 || FIFO_DEPTH < 2) begin : g_bad_cfg
        $error("serial clock too fast for mclk or fifo too shallow");
    end

    sss_pkg::sss_state_t st_reg;
    sss_pkg::sss_state_t st_next;

    logic [2:0]                 s_pins;
    logic                       s_sclk;
    logic                       s_cs;
    logic                       s_mosi;
    logic                       sclk_rise;
    logic                       sclk_fall;
    logic                       cs_rise;
    logic                       cs_fall;
    logic                       fifo_in_valid;
    logic                       fifo_in_ready;
    logic [WW-1:0]              fifo_out_data;

    // link pins through two flops
    sss_sync #(
        .WIDTH(3),
        .INIT (3'h2) // select idles high, clock idles low
    ) u_sync (
        .mclk     (mclk),
        .rst      (rst),
        .async_in ({sclk, frame_select_low, mosi}),
        .sync_out (s_pins)
    );

    assign s_sclk = s_pins[2];
    assign s_cs   = s_pins[1];
    assign s_mosi = s_pins[0];

    // edges of the synchronised link signals
    assign sclk_rise = s_sclk && !st_reg.sclk_d;
    assign sclk_fall = !s_sclk && st_reg.sclk_d;
    assign cs_rise   = s_cs && !st_reg.cs_d;
    assign cs_fall   = !s_cs && st_reg.cs_d;

    // register lookup: {valid, writable, value}
    function automatic logic [15:0] look(input logic [`SSS_DATA_BITS-1:0] a);
        logic [15:0] res;
        res = {2'b00, `SSS_RESET_WORD};
        if (a >= `SSS_ADDR_NV_FIRST && a <= `SSS_ADDR_NV_LAST) begin
            res = {2'b11, st_reg.nv[3'(a - `SSS_ADDR_NV_FIRST)]};
        end else begin
            case (a)
                `SSS_ADDR_NOP:      res = {2'b10, `SSS_RESET_WORD};
                `SSS_ADDR_FAULT:    res = {2'b10, 11'h000, st_reg.faults};
                `SSS_ADDR_PROG:     res = {2'b11, st_reg.prog};
                `SSS_ADDR_DIAG:     res = {2'b10, diag_word};
                `SSS_ADDR_MAG:      res = {2'b10, magnitude};
                `SSS_ADDR_ANG_RAW:  res = {2'b10, angle_raw};
                `SSS_ADDR_ANG_COMP: res = {2'b10, angle_comp};
                default:            res = {2'b00, `SSS_RESET_WORD};
            endcase
        end
        return res;
    endfunction

    logic [2:0]                  err;
    logic                        clr;
    logic                        par_ok;
    logic [15:0]                 lk;
    logic [`SSS_DATA_BITS-1:0]   dout;
    logic                        ef;

    // shifting, frame-end execution and register updates
    always_comb begin
        st_next        = st_reg;
        err            = 3'h0;
        clr            = 1'b0;
        par_ok         = ~^st_reg.rx;
        lk             = look(st_reg.rx[`SSS_DATA_BITS-1:0]);
        dout           = `SSS_RESET_WORD;
        ef             = 1'b0;
        fifo_in_valid  = 1'b0;
        st_next.sclk_d = s_sclk;
        st_next.cs_d   = s_cs;
        if (cs_fall) begin
            st_next.bits = 5'h00;
            st_next.oe   = 1'b1;
            st_next.miso = 1'b0;
        end else if (!s_cs) begin
            if (sclk_rise) begin
                st_next.miso = st_reg.tx[`SSS_PAR_BIT];
                st_next.tx   = {st_reg.tx[`SSS_FRAME_BITS-2:0], 1'b0};
            end
            if (sclk_fall) begin
                st_next.rx = {st_reg.rx[`SSS_FRAME_BITS-2:0], s_mosi};
                if (st_reg.bits != `SSS_BITS_SAT) begin
                    st_next.bits = st_reg.bits + 5'h01;
                end
            end
        end
        // execute only when the frame closes
        if (cs_rise) begin
            st_next.oe   = 1'b0;
            st_next.miso = 1'b0;
            st_next.phase = sss_pkg::SSS_PH_CMD;
            if (st_reg.bits != `SSS_BITS_FULL) begin
                err[`SSS_FLT_FRAME] = 1'b1;
            end else if (st_reg.phase == sss_pkg::SSS_PH_DATA) begin
                lk   = look(st_reg.wr_addr);
                dout = lk[`SSS_DATA_BITS-1:0];
                if (!par_ok) begin
                    err[`SSS_FLT_PARITY] = 1'b1;
                end else if (st_reg.rx[`SSS_RW_BIT] || !fifo_in_ready) begin
                    err[`SSS_FLT_FRAME] = 1'b1;
                end else begin
                    fifo_in_valid = 1'b1;
                    dout          = st_reg.rx[`SSS_DATA_BITS-1:0];
                    if (st_reg.wr_addr == `SSS_ADDR_PROG) begin
                        st_next.prog = st_reg.rx[`SSS_DATA_BITS-1:0];
                    end else begin
                        st_next.nv[3'(st_reg.wr_addr - `SSS_ADDR_NV_FIRST)] = st_reg.rx[`SSS_DATA_BITS-1:0];
                    end
                end
            end else if (!par_ok) begin
                err[`SSS_FLT_PARITY] = 1'b1;
            end else if (!lk[15] || (!st_reg.rx[`SSS_RW_BIT] && !lk[14])) begin
                err[`SSS_FLT_ADDR] = 1'b1;
            end else if (st_reg.rx[`SSS_RW_BIT]) begin
                dout = lk[`SSS_DATA_BITS-1:0];
                clr  = st_reg.rx[`SSS_DATA_BITS-1:0] == `SSS_ADDR_FAULT;
            end else begin
                st_next.phase   = sss_pkg::SSS_PH_DATA;
                st_next.wr_addr = st_reg.rx[`SSS_DATA_BITS-1:0];
                dout            = lk[`SSS_DATA_BITS-1:0];
            end
            ef             = |err;
            st_next.tx     = {^{ef, dout}, ef, dout};
            // new faults win over the clear of the same frame
            st_next.faults = (clr ? `SSS_RESET_FAULTS : st_reg.faults) | err;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg        <= '0;
            st_reg.sclk_d <= 1'b0;
            st_reg.cs_d   <= 1'b1;
            st_reg.tx     <= `SSS_RESET_TX;
        end else begin
            st_reg <= st_next;
        end
    end

    // committed writes go out through the buffer
    sss_fifo #(
        .WIDTH(WW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({st_reg.wr_addr, st_reg.rx[`SSS_DATA_BITS-1:0]}),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (fifo_out_data)
    );

    // outputs straight from flops
    assign wr_addr              = fifo_out_data[WW-1:`SSS_DATA_BITS];
    assign wr_data              = fifo_out_data[`SSS_DATA_BITS-1:0];
    assign miso_out             = st_reg.miso;
    assign miso_oe              = st_reg.oe;
    assign prog_word            = st_reg.prog;
    assign nv_settings          = st_reg.nv;
    assign fault_latch_register = st_reg.faults;

    // checks on the frame engine
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic cmd_ok;
    assign cmd_ok = cs_rise && st_reg.bits == `SSS_BITS_FULL && st_reg.phase == sss_pkg::SSS_PH_CMD;

    property p_capture_fall;
        !s_cs && !cs_fall && sclk_fall |=> st_reg.rx[0] == $past(s_mosi);
    endproperty
    a_capture_fall: assert property (p_capture_fall) else $error("mosi bit not captured");

    property p_msb_out;
        !s_cs && !cs_fall && sclk_rise |=> miso_out == $past(st_reg.tx[15]) ##1 1'b1;
    endproperty
    a_msb_out: assert property (p_msb_out) else $error("miso not msb first");

    property p_no_mid_exec;
        !cs_rise |=> fault_latch_register == $past(fault_latch_register) && st_reg.phase == $past(st_reg.phase);
    endproperty
    a_no_mid_exec: assert property (p_no_mid_exec) else $error("state changed outside frame end");

    property p_tx_parity;
        cs_rise |=> !(^st_reg.tx) && !miso_oe;
    endproperty
    a_tx_parity: assert property (p_tx_parity) else $error("returned frame parity odd");

    property p_frame_fault;
        cs_rise && st_reg.bits != `SSS_BITS_FULL |=> st_reg.tx[14] && fault_latch_register[0];
    endproperty
    a_frame_fault: assert property (p_frame_fault) else $error("short frame not flagged");

    property p_parity_fault;
        cmd_ok && (^st_reg.rx) |=> fault_latch_register[2] && st_reg.tx[14] && st_reg.phase == sss_pkg::SSS_PH_CMD;
    endproperty
    a_parity_fault: assert property (p_parity_fault) else $error("parity fault missed");

    property p_bad_addr;
        cmd_ok && !(^st_reg.rx) && st_reg.rx[13:0] == 14'h0002 |=> fault_latch_register[1];
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("bad address not flagged");

    property p_read_angle;
        cmd_ok && !(^st_reg.rx) && st_reg.rx[14] && st_reg.rx[13:0] == `SSS_ADDR_ANG_COMP
            |=> st_reg.tx[13:0] == $past(angle_comp) && !st_reg.tx[14];
    endproperty
    a_read_angle: assert property (p_read_angle) else $error("angle read value wrong");

    property p_fault_clear;
        cmd_ok && !(^st_reg.rx) && st_reg.rx[14] && st_reg.rx[13:0] == `SSS_ADDR_FAULT
            |=> fault_latch_register == 3'h0 && st_reg.tx[2:0] == $past(fault_latch_register);
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault latch not cleared on read");

    property p_write_echo;
        fifo_in_valid |=> st_reg.tx[13:0] == $past(st_reg.rx[13:0]) ##1 wr_valid || $past(wr_valid);
    endproperty
    a_write_echo: assert property (p_write_echo) else $error("written value not echoed");

    property p_write_old;
        cmd_ok && !(^st_reg.rx) && !st_reg.rx[14] && st_reg.rx[13:0] == `SSS_ADDR_PROG
            |=> st_reg.tx[13:0] == $past(prog_word) && st_reg.phase == sss_pkg::SSS_PH_DATA;
    endproperty
    a_write_old: assert property (p_write_old) else $error("old content not returned");

    c_read: cover property (cmd_ok && st_reg.rx[14] && !(^st_reg.rx));
    c_write: cover property (fifo_in_valid);
    c_parity_err: cover property (cmd_ok && (^st_reg.rx));
    c_fifo_full: cover property (!fifo_in_ready);
endmodule

// ### dv/sss_host.sv
/* host master model of the serial link, mode 1, msb first.
   assumes mclk of 25 ns; a bit period is 8 mclk (200 ns). */
`timescale 1ns/1ps

module sss_host (
    // clock
    input  wire logic mclk,
    // link
    output logic      sclk,
    output logic      frame_select_low,
    output logic      mosi,
    input  wire logic miso_out
);
    // idle: clock low, select high
    initial begin
        sclk = 1'b0;
        frame_select_low = 1'b1;
        mosi = 1'b0;
    end

    // one frame of n bits; miso taken at the end of each bit
    task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        frame_select_low = 1'b0;
        repeat (16) @(negedge mclk);
        for (int i = 15; i > 15 - n; i--) begin
            sclk = 1'b1;
            mosi = tx[i];
            repeat (4) @(negedge mclk);
            sclk = 1'b0;
            repeat (4) @(negedge mclk);
            rx[i] = miso_out;
        end
        frame_select_low = 1'b1;
        mosi = ~mosi; // released line shows no stale level
        repeat (16) @(negedge mclk);
    endtask
endmodule

// ### dv/sss_spi_slave_tb.sv
/* self-checking bench of the serial slave: reads, writes, faults, buffer.
   assumes the host model drives the link; inputs change at mclk fall. */
`timescale 1ns/1ps
`include "sss_cfg.svh"

module sss_spi_slave_tb;
    logic             mclk;
    logic             rst;
    logic             sclk;
    logic             frame_select_low;
    logic             mosi;
    logic             miso_out;
    logic             miso_oe;
    logic             wr_valid;
    logic             wr_ready;
    logic [13:0]      sens [4];
    logic [13:0]      adr [4];
    logic [13:0]      prog_word;
    logic [13:0]      wr_addr;
    logic [13:0]      wr_data;
    logic [13:0]      v;
    logic [4:0][13:0] nv;
    logic [2:0]       flt;
    logic [15:0]      rx;
    int               err_count = 0;
    int               checks_done = 0;
    int               cyc = 0;
    int               n;
    int               pops = 0;
    logic             oe_hi = 1'b0;

    // clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    sss_spi_slave #(.FIFO_DEPTH(2)) u_dut (
        .mclk(mclk), .rst(rst), .sclk(sclk), .frame_select_low(frame_select_low),
        .mosi(mosi), .miso_out(miso_out), .miso_oe(miso_oe), .diag_word(sens[0]),
        .magnitude(sens[1]), .angle_raw(sens[2]), .angle_comp(sens[3]),
        .prog_word(prog_word), .nv_settings(nv), .fault_latch_register(flt),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data)
    );

    sss_host u_host (
        .mclk(mclk), .sclk(sclk), .frame_select_low(frame_select_low),
        .mosi(mosi), .miso_out(miso_out)
    );

    // frame word with even parity on top
    function automatic logic [15:0] word(input logic b14, input logic [13:0] d);
        return {^{b14, d}, b14, d};
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic xf(input logic [15:0] t, input int nb = 16);
        u_host.frame(t, nb, rx);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            final_report();
        end
    end

    // remembers that the slave drove miso during some frame
    always @(negedge mclk) begin
        if (miso_oe === 1'b1) oe_hi = 1'b1;
    end

    // main sequence
    initial begin
        rst = 1'b1;
        wr_ready = 1'b0;
        void'($urandom(40));
        adr = '{`SSS_ADDR_DIAG, `SSS_ADDR_MAG, `SSS_ADDR_ANG_RAW, `SSS_ADDR_ANG_COMP};
        foreach (sens[i]) sens[i] = 14'($urandom);
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        chk("oe", 16'h0, 16'(miso_oe));
        chk("prog", 16'h0, 16'(prog_word));
        chk("fault", 16'h0, 16'(flt));
        chk("wr_valid", 16'h0, 16'(wr_valid));
        $display("test reset done");
        // pipelined reads of every sensor word
        for (int i = 0; i < 4; i++) begin
            xf(word(1'b1, adr[i]));
            chk("read", i == 0 ? 16'h0 : word(1'b0, sens[i-1]), rx);
        end
        xf(word(1'b1, `SSS_ADDR_NOP));
        chk("angle", word(1'b0, sens[3]), rx);
        chk("oe idle", 16'h0, 16'(miso_oe));
        chk("oe busy", 16'h1, 16'(oe_hi));
        $display("test reads done");
        // write with the consumer stalled
        v = 14'($urandom);
        xf(word(1'b0, `SSS_ADDR_PROG));
        xf(word(1'b0, v));
        chk("old", 16'h0, rx);
        xf(word(1'b1, `SSS_ADDR_NOP));
        chk("new", word(1'b0, v), rx);
        chk("prog_word", 16'(v), 16'(prog_word));
        chk("wr", {1'b1, 1'b0, `SSS_ADDR_PROG}, {wr_valid, 1'b0, wr_addr});
        chk("wr_data", 16'(v), 16'(wr_data));
        wr_ready = 1'b1;
        @(negedge mclk);
        wr_ready = 1'b0;
        repeat (2) @(negedge mclk);
        chk("drained", 16'h0, 16'(wr_valid));
        $display("test write done");
        // parity, bad address and framing faults, each cleared by a read
        for (int k = 0; k < 3; k++) begin
            if (k == 0) xf(word(1'b1, `SSS_ADDR_NOP) ^ 16'h8000);
            else if (k == 1) xf(word(1'b1, 14'h0100));
            else xf(word(1'b1, `SSS_ADDR_NOP), 8);
            chk("latch", 16'(3'b100 >> k), 16'(flt));
            xf(word(1'b1, `SSS_ADDR_FAULT));
            chk("ef", 16'h1, 16'(rx[14]));
            xf(word(1'b1, `SSS_ADDR_NOP));
            chk("fault word", word(1'b0, 14'(3'b100 >> k)), rx);
            chk("cleared", 16'h0, 16'(flt));
        end
        $display("test faults done");
        // fill the buffer until a write is refused, then drain it
        n = 0;
        for (int i = 0; i < 5 && flt[0] !== 1'b1; i++) begin
            xf(word(1'b0, `SSS_ADDR_NV_FIRST + 14'(i)));
            xf(word(1'b0, 14'(i + 1)));
            if (flt[0] !== 1'b1) n++;
        end
        chk("full", 16'h1, 16'(flt[0]));
        chk("nv0", 16'h1, 16'(nv[0]));
        wr_ready = 1'b1;
        // look at the head word at mclk fall, the next rise pops it
        for (int k = 0; k < 8; k++) begin
            if (wr_valid === 1'b1) begin
                chk("pop", 16'(k + 1), 16'(wr_data));
                chk("pop addr", 16'(`SSS_ADDR_NV_FIRST + 14'(k)), 16'(wr_addr));
                pops++;
            end
            @(negedge mclk);
        end
        wr_ready = 1'b0;
        chk("empty", 16'h0, 16'(wr_valid));
        chk("pops", 16'(n), 16'(pops));
        xf(word(1'b1, `SSS_ADDR_NV_FIRST + 14'h0001));
        xf(word(1'b1, `SSS_ADDR_NOP));
        chk("nv read", word(1'b0, 14'h0002), rx);
        $display("test buffer done, %0d words", n);
        final_report();
    end
endmodule
